//--- bsr_pkg.sv
// constants, operation codes and select decoding for the eight-bit shift register
// assumes selects and data come from logic on the same clock as the register
package bsr_pkg;

    localparam int            REG_WIDTH    = 8;
    localparam int            FIFO_DEPTH   = 16;
    localparam logic [7:0]    REG_RESET    = 8'h00;

    // select field positions inside the packed {high, low} pair
    localparam int            SEL_LOW_POS  = 0;
    localparam int            SEL_HIGH_POS = 1;

    localparam logic [1:0]    MODE_LOAD       = 2'h0;
    localparam logic [1:0]    MODE_SHIFT_HIGH = 2'h1;
    localparam logic [1:0]    MODE_SHIFT_LOW  = 2'h2;
    localparam logic [1:0]    MODE_HOLD       = 2'h3;

    typedef enum logic [3:0] {
        OP_LOAD       = 4'h1,
        OP_SHIFT_HIGH = 4'h2,
        OP_SHIFT_LOW  = 4'h4,
        OP_HOLD       = 4'h8
    } bsr_op_type;

    // every select code is legal, so no default is needed
    function automatic bsr_op_type bsr_decode(input logic [1:0] sel);
        bsr_op_type op;
        op = OP_HOLD;
        unique case (sel)
            MODE_LOAD:       op = OP_LOAD;
            MODE_SHIFT_HIGH: op = OP_SHIFT_HIGH;
            MODE_SHIFT_LOW:  op = OP_SHIFT_LOW;
            MODE_HOLD:       op = OP_HOLD;
        endcase
        return op;
    endfunction

endpackage

//--- bsr_fifo.sv
// first-in first-out buffer with a registered output stage
// assumes one clock, synchronous active-high reset, depth a power of two
`timescale 1ns/10ps
module bsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // draining side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int            AW         = $clog2(DEPTH);
    localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             in_ready_q;
    logic             out_valid_q;
    logic [WIDTH-1:0] out_data_q;

    wire logic push    = i_in_valid && in_ready_q;
    wire logic pop_mem = (count_q != '0) && (!out_valid_q || i_out_ready);

    assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};

    // ready is registered so the source sees it straight from a flop
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q       <= '0;
            rd_q       <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b1;
        end else begin
            wr_q       <= push ? wr_q + 1'b1 : wr_q;
            rd_q       <= pop_mem ? rd_q + 1'b1 : rd_q;
            count_q    <= count_d;
            in_ready_q <= (count_d != FULL_COUNT);
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else if (pop_mem) begin
            out_valid_q <= 1'b1;
            out_data_q  <= mem_q[rd_q];
        end else if (i_out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

    assign o_in_ready  = in_ready_q;
    assign o_out_valid = out_valid_q;
    assign o_out_data  = out_data_q;

    chk_fifo_bound: assert property (@(posedge i_clk) disable iff (i_rst)
        count_q <= FULL_COUNT)
        else $error("fifo count beyond depth");

    chk_fifo_ready: assert property (@(posedge i_clk) disable iff (i_rst)
        (count_q == FULL_COUNT) |-> !in_ready_q)
        else $error("fifo ready while full");

    chk_fifo_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (out_valid_q && !i_out_ready) |=> (out_valid_q && $stable(out_data_q)))
        else $error("fifo output dropped while stalled");

endmodule

//--- bsr_shift_top.sv
// eight-bit register with parallel load, hold and shifts in both directions
// assumes selects and data are driven by logic on I_CLK; results stream out through a fifo
`timescale 1ns/10ps
module bsr_shift_top (
    // clock and reset
    input  wire logic                            I_CLK,
    input  wire logic                            I_SYS_RST,
    // operation select
    input  wire logic                            I_MODE_SELECT_LOW,
    input  wire logic                            I_MODE_SELECT_HIGH,
    // data in
    input  wire logic                            I_SERIAL_IN_LOW_END,
    input  wire logic                            I_SERIAL_IN_HIGH_END,
    input  wire logic [bsr_pkg::REG_WIDTH-1:0]   I_PARALLEL_LOAD_IN,
    // register state
    output logic      [bsr_pkg::REG_WIDTH-1:0]   O_REGISTER_OUT,
    output logic                                 O_OP_READY,
    // result stream
    output logic                                 O_STREAM_VALID,
    output logic      [bsr_pkg::REG_WIDTH-1:0]   O_STREAM_DATA,
    input  wire logic                            I_STREAM_READY
);
    import bsr_pkg::*;

    logic [REG_WIDTH-1:0] reg_q;
    logic [REG_WIDTH-1:0] reg_d;
    logic                 fifo_in_ready;

    // decoding of the two selects
    wire logic [1:0] sel_pair = {I_MODE_SELECT_HIGH, I_MODE_SELECT_LOW};
    wire bsr_op_type op       = bsr_decode(sel_pair);

    wire logic is_hold = (op == OP_HOLD);
    wire logic is_load = (op == OP_LOAD);
    wire logic is_shh  = (op == OP_SHIFT_HIGH);
    wire logic is_shl  = (op == OP_SHIFT_LOW);

    // a change of state needs room for its result, else the operation waits
    wire logic apply = !is_hold && fifo_in_ready;
    wire logic stall = !is_hold && !fifo_in_ready;

    // candidate next values
    wire logic [REG_WIDTH-1:0] load_val = I_PARALLEL_LOAD_IN;
    wire logic [REG_WIDTH-1:0] shh_val  =
        {reg_q[REG_WIDTH-2:0], I_SERIAL_IN_LOW_END};
    wire logic [REG_WIDTH-1:0] shl_val  =
        {I_SERIAL_IN_HIGH_END, reg_q[REG_WIDTH-1:1]};

    wire logic [REG_WIDTH-1:0] op_val =
        is_load ? load_val :
        is_shh  ? shh_val  :
        is_shl  ? shl_val  : reg_q;

    assign reg_d = apply ? op_val : reg_q;

    // state moves only on the rising edge
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            reg_q <= REG_RESET;
        end else begin
            reg_q <= reg_d;
        end
    end

    // every applied operation queues its new value
    bsr_fifo #(
        .WIDTH (REG_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK),
        .i_rst       (I_SYS_RST),
        .i_in_valid  (apply),
        .i_in_data   (op_val),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (O_STREAM_VALID),
        .o_out_data  (O_STREAM_DATA),
        .i_out_ready (I_STREAM_READY)
    );

    assign O_REGISTER_OUT = reg_q;
    assign O_OP_READY     = fifo_in_ready;

    // checking aid only: words held in queue memory and output stage together
    logic [5:0] held_q;
    logic [5:0] held_d;
    wire logic  word_out  = O_STREAM_VALID && I_STREAM_READY;
    wire logic  held_full = (held_q >= 6'(FIFO_DEPTH));

    assign held_d = held_q + {5'h00, apply} - {5'h00, word_out};

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            held_q <= 6'h00;
        end else begin
            held_q <= held_d;
        end
    end

    sequence seq_load_taken;
        apply && is_load;
    endsequence

    sequence seq_shh_taken;
        apply && is_shh;
    endsequence

    sequence seq_shl_taken;
        apply && is_shl;
    endsequence

    chk_decode_onehot: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        $onehot(op) && (is_hold == (sel_pair == MODE_HOLD)))
        else $error("select decode not one-hot");

    chk_load_copy: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        seq_load_taken |=> (O_REGISTER_OUT == $past(I_PARALLEL_LOAD_IN)))
        else $error("parallel load value wrong");

    chk_shift_high: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        seq_shh_taken |=> (O_REGISTER_OUT[REG_WIDTH-1:1] == $past(reg_q[REG_WIDTH-2:0])))
        else $error("shift toward high end wrong");

    chk_fill_low: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        seq_shh_taken |=> (O_REGISTER_OUT[0] == $past(I_SERIAL_IN_LOW_END)))
        else $error("low end fill bit wrong");

    chk_shift_low: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        seq_shl_taken |=> (O_REGISTER_OUT == {$past(I_SERIAL_IN_HIGH_END),
                                             $past(reg_q[REG_WIDTH-1:1])}))
        else $error("shift toward low end wrong");

    chk_hold_keep: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_hold || stall) |=> $stable(O_REGISTER_OUT))
        else $error("register changed without an applied operation");

    chk_queue_value: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (apply && !O_STREAM_VALID) ##1 (!O_STREAM_VALID)
        |=> (O_STREAM_VALID && O_STREAM_DATA == $past(O_REGISTER_OUT, 1)))
        else $error("queued value does not match register");

    chk_stall_ready: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        stall |-> !O_OP_READY ##0 held_full)
        else $error("stall without a full queue");

    // reset must leave a cleared register, an empty stream and room to queue
    chk_reset_state: assert property (
        @(posedge I_CLK)
        I_SYS_RST |=> ((O_REGISTER_OUT == REG_RESET) && !O_STREAM_VALID && O_OP_READY))
        else $error("state not cleared by reset");

    chk_decode_map: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_load == (sel_pair == MODE_LOAD)) && (is_shh == (sel_pair == MODE_SHIFT_HIGH))
        && (is_shl == (sel_pair == MODE_SHIFT_LOW)))
        else $error("select code mapped to wrong operation");

    chk_hold_pair: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (sel_pair[SEL_HIGH_POS] && sel_pair[SEL_LOW_POS])
        |=> ($stable(O_REGISTER_OUT) && (held_q <= $past(held_q))))
        else $error("both selects high did not hold");

    chk_top_from_six: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        seq_shh_taken |=> (O_REGISTER_OUT[REG_WIDTH-1] == $past(O_REGISTER_OUT[REG_WIDTH-2])))
        else $error("top bit not taken from bit six");

    chk_fill_high: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        seq_shl_taken |=> (O_REGISTER_OUT[REG_WIDTH-1] == $past(I_SERIAL_IN_HIGH_END)))
        else $error("high end fill bit wrong");

    // a one-edge reset may also move the register, so it counts as a cause
    chk_change_cause: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        $changed(O_REGISTER_OUT) |-> ($past(apply) || $past(I_SYS_RST)))
        else $error("register moved without an applied operation");

    chk_ready_room: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_OP_READY |-> (held_q <= 6'(FIFO_DEPTH)))
        else $error("ready while queue holds too much");

    chk_ready_full: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        !O_OP_READY |-> held_full)
        else $error("ready low with room in queue");

    chk_held_bound: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        held_q <= 6'(FIFO_DEPTH + 1))
        else $error("more words queued than memory and stage hold");

    // per-bit view of load and both shifts, so a fault names its bit
    for (genvar n = 0; n < REG_WIDTH; n++) begin : g_bit_chk
        chk_bit_load: assert property (
            @(posedge I_CLK) disable iff (I_SYS_RST)
            seq_load_taken |=> (O_REGISTER_OUT[n] == $past(I_PARALLEL_LOAD_IN[n])))
            else $error("parallel load bit wrong");
        if (n > 0) begin : g_up
            chk_bit_up: assert property (
                @(posedge I_CLK) disable iff (I_SYS_RST)
                seq_shh_taken |=> (O_REGISTER_OUT[n] == $past(O_REGISTER_OUT[n-1])))
                else $error("bit not moved toward high end");
        end
        if (n < REG_WIDTH-1) begin : g_down
            chk_bit_down: assert property (
                @(posedge I_CLK) disable iff (I_SYS_RST)
                seq_shl_taken |=> (O_REGISTER_OUT[n] == $past(O_REGISTER_OUT[n+1])))
                else $error("bit not moved toward low end");
        end
    end

endmodule

//--- bsr_sink.sv
// consumer of the result stream at the far side of the register
// assumes the bench's clock; the bench says when it stalls
`timescale 1ns/10ps
module bsr_sink (
    // clock and control
    input  wire logic       i_clk,
    input  wire logic       i_stall,
    // stream in
    input  wire logic       i_valid,
    input  wire logic [7:0] i_data,
    output logic            o_ready,
    // popped word
    output logic            o_pop,
    output logic [7:0]      o_word
);
    initial o_ready = 1'b0;
    // ready moves just after the edge so it is never sampled mid-change
    always @(posedge i_clk) o_ready <= #1 !i_stall;
    assign o_pop  = i_valid && o_ready;
    assign o_word = i_data;
endmodule

//--- bsr_shift_top_tb.sv
// self-checking bench for the eight-bit shift register and its result stream
// assumes bsr_pkg, bsr_shift_top, bsr_fifo and bsr_sink are compiled first
`timescale 1ns/10ps
module bsr_shift_top_tb;
    import bsr_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, sel_lo = 1'b1, sel_hi = 1'b1;
    logic        ser_lo = 1'b0, ser_hi = 1'b0, stall = 1'b0;
    logic [7:0]  par = 8'h00, q_out, s_data, word, exp = 8'h00;
    logic        op_rdy, s_valid, s_ready, pop;
    logic [7:0]  fifo_q[$];
    logic [31:0] seed = 32'h7dc86293;
    int          error_cnt = 0, checked = 0, cyc = 0;
    always #20 clk = ~clk;
    bsr_shift_top i_bsr_shift_top (.I_CLK(clk), .I_SYS_RST(rst), .I_MODE_SELECT_LOW(sel_lo),
        .I_MODE_SELECT_HIGH(sel_hi), .I_SERIAL_IN_LOW_END(ser_lo),
        .I_SERIAL_IN_HIGH_END(ser_hi), .I_PARALLEL_LOAD_IN(par), .O_REGISTER_OUT(q_out),
        .O_OP_READY(op_rdy), .O_STREAM_VALID(s_valid), .O_STREAM_DATA(s_data),
        .I_STREAM_READY(s_ready));
    bsr_sink i_bsr_sink (.i_clk(clk), .i_stall(stall), .i_valid(s_valid), .i_data(s_data),
        .o_ready(s_ready), .o_pop(pop), .o_word(word));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] next_val(input logic [7:0] q, input logic [1:0] s,
                                            input logic [7:0] p, input logic lo, input logic hi);
        case (s)
            MODE_LOAD:       return p;
            MODE_SHIFT_HIGH: return {q[6:0], lo};
            MODE_SHIFT_LOW:  return {hi, q[7:1]};
            default:         return q;
        endcase
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic drive(input logic [1:0] s, input logic [7:0] p, input logic lo, input logic hi);
        @(posedge clk);
        #1;
        {sel_hi, sel_lo} = s;
        par = p;
        ser_lo = lo;
        ser_hi = hi;
    endtask
    task automatic random_run(input int n);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            stall = seed[20] & seed[21];
            drive(seed[1:0], seed[15:8], seed[16], seed[17]);
        end
    endtask
    // reference model: a refused operation leaves the register alone
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            conclude();
        end else if (rst) begin
            exp = REG_RESET;
            fifo_q.delete();
        end else begin
            check("ready", op_rdy, (fifo_q.size() - int'(s_valid)) != FIFO_DEPTH);
            if (pop) begin
                check("stream", word, (fifo_q.size() > 0) ? fifo_q.pop_front() : 8'h00);
            end
            if ({sel_hi, sel_lo} != MODE_HOLD && op_rdy === 1'b1) begin
                exp = next_val(exp, {sel_hi, sel_lo}, par, ser_lo, ser_hi);
                fifo_q.push_back(exp);
            end
        end
    end
    // mid-phase look: nothing may move while the clock level is steady
    always @(negedge clk) begin
        if (cyc > 0) check("register", q_out, exp);
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        drive(MODE_LOAD, 8'ha5, 1'b1, 1'b1);
        drive(MODE_SHIFT_HIGH, 8'h00, 1'b1, 1'b1);
        drive(MODE_SHIFT_LOW, 8'hff, 1'b1, 1'b0);
        drive(MODE_HOLD, 8'h3c, 1'b1, 1'b1);
        #1 check("walk", q_out, 8'h25);
        random_run(200);
        stall = 1'b1;
        for (int i = 0; i < 30; i++) drive(MODE_SHIFT_HIGH, 8'h00, i[0], 1'b0);
        stall = 1'b0;
        random_run(40);
        stall = 1'b0;
        drive(MODE_HOLD, 8'h00, 1'b0, 1'b0);
        repeat (40) @(posedge clk);
        #1 check("queue left", 8'(fifo_q.size()), 8'h00);
        drive(MODE_LOAD, 8'hff, 1'b0, 1'b0);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        random_run(100);
        conclude();
    end
endmodule
